// file: rtl/peripheral_dma_unit.sv
/*
 * Peripheral DMA channel pair: register file, enable control and transfer engine.
 * Assumes the serial peripheral and the memory port run on MCLK, the peripheral
 * drops its ready within one cycle of the holding strobe, and memory acknowledges
 * each request with a one-cycle MEM_ACK.
 */
module peripheral_dma_unit #(
    parameter bit HALF_DUPLEX = 1'b0
) (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [peripheral_dma_pkg::ADDR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [1:0] XFER_SIZE,
    input wire logic RX_READY,
    input wire logic [31:0] RX_HOLD_DATA,
    output logic RX_HOLD_RD,
    input wire logic TX_READY,
    output logic [31:0] TX_HOLD_DATA,
    output logic TX_HOLD_WR,
    output logic MEM_REQ,
    output peripheral_dma_pkg::mem_cmd_t MEM_CMD,
    input wire logic MEM_ACK,
    input wire logic [31:0] MEM_RDATA,
    output logic RX_END,
    output logic RX_FULL,
    output logic TX_END,
    output logic TX_EMPTY
);

    // Half duplex folds the transmit view onto channel 0 storage.
    localparam logic TXC = HALF_DUPLEX ? 1'b0 : 1'b1;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction : merge

    logic [31:0] cur_ptr_r [2];
    logic [15:0] cur_cnt_r [2];
    logic [31:0] nxt_ptr_r [2];
    logic [15:0] nxt_cnt_r [2];
    logic [1:0] end_r;
    logic rx_en_r;
    logic tx_en_r;
    logic rx_en_nxt;
    logic tx_en_nxt;
    logic ack_r;
    logic [31:0] dat_o_r;
    logic [31:0] rd_data;
    peripheral_dma_pkg::engine_state_t state_r;
    peripheral_dma_pkg::engine_state_t state_nxt;
    logic dch_r;
    logic rd_r;
    logic wr_r;
    logic [31:0] tx_hold_r;
    peripheral_dma_pkg::mem_cmd_t cmd_r;

    // Bus decode; a request is answered once, in the cycle after it is seen.
    wire wb_req = WB_CYC_I & WB_STB_I & ~ack_r;
    wire wb_wr = wb_req & WB_WE_I;
    wire wb_rd = wb_req & ~WB_WE_I;
    wire hit_rcp = WB_ADR_I == peripheral_dma_pkg::OFF_RX_CUR_PTR;
    wire hit_rcc = WB_ADR_I == peripheral_dma_pkg::OFF_RX_CUR_CNT;
    wire hit_tcp = WB_ADR_I == peripheral_dma_pkg::OFF_TX_CUR_PTR;
    wire hit_tcc = WB_ADR_I == peripheral_dma_pkg::OFF_TX_CUR_CNT;
    wire hit_rnp = WB_ADR_I == peripheral_dma_pkg::OFF_RX_NXT_PTR;
    wire hit_rnc = WB_ADR_I == peripheral_dma_pkg::OFF_RX_NXT_CNT;
    wire hit_tnp = WB_ADR_I == peripheral_dma_pkg::OFF_TX_NXT_PTR;
    wire hit_tnc = WB_ADR_I == peripheral_dma_pkg::OFF_TX_NXT_CNT;
    wire hit_ctl = WB_ADR_I == peripheral_dma_pkg::OFF_CTRL;
    wire hit_st = WB_ADR_I == peripheral_dma_pkg::OFF_STATE;

    // Per-channel write strobes; in half duplex both views land on channel 0.
    wire [1:0] wr_cp = {wb_wr & hit_tcp & ~TXC ? 1'b0 : wb_wr & hit_tcp & TXC,
                        wb_wr & (hit_rcp | (hit_tcp & ~TXC))}; // R10
    wire [1:0] wr_cc = {wb_wr & hit_tcc & TXC, wb_wr & (hit_rcc | (hit_tcc & ~TXC))};
    wire [1:0] wr_np = {wb_wr & hit_tnp & TXC, wb_wr & (hit_rnp | (hit_tnp & ~TXC))};
    wire [1:0] wr_nc = {wb_wr & hit_tnc & TXC, wb_wr & (hit_rnc | (hit_tnc & ~TXC))};
    wire wb_chan = (hit_tcp | hit_tcc | hit_tnp | hit_tnc) & TXC;

    wire [31:0] new_cp = merge(cur_ptr_r[wb_chan], WB_DAT_I, WB_SEL_I);
    wire [31:0] new_cc = merge({16'h0, cur_cnt_r[wb_chan]}, WB_DAT_I, WB_SEL_I);
    wire [31:0] new_np = merge(nxt_ptr_r[wb_chan], WB_DAT_I, WB_SEL_I);
    wire [31:0] new_nc = merge({16'h0, nxt_cnt_r[wb_chan]}, WB_DAT_I, WB_SEL_I);

    // Control strobes act only on bits whose byte lane is selected.
    wire ctl_wr = wb_wr & hit_ctl;
    wire rx_on = ctl_wr & WB_SEL_I[0] & WB_DAT_I[peripheral_dma_pkg::CTRL_RX_EN_BIT];
    wire rx_off = ctl_wr & WB_SEL_I[0] & WB_DAT_I[peripheral_dma_pkg::CTRL_RX_DIS_BIT];
    wire tx_on = ctl_wr & WB_SEL_I[1] & WB_DAT_I[peripheral_dma_pkg::CTRL_TX_EN_BIT];
    wire tx_off = ctl_wr & WB_SEL_I[1] & WB_DAT_I[peripheral_dma_pkg::CTRL_TX_DIS_BIT];

    // In half duplex a disable outranks every enable, and receive outranks transmit,
    // so even a forbidden write of both enables leaves at most one direction on.
    always_comb begin
        rx_en_nxt = rx_en_r;
        tx_en_nxt = tx_en_r;
        if (HALF_DUPLEX) begin
            if (rx_off | tx_off) begin
                rx_en_nxt = 1'b0; // R17 R18
                tx_en_nxt = 1'b0;
            end else if (rx_on) begin
                rx_en_nxt = 1'b1; // R15 R11
                tx_en_nxt = 1'b0;
            end else if (tx_on) begin
                tx_en_nxt = 1'b1; // R19 R13
                rx_en_nxt = 1'b0;
            end
        end else begin
            if (rx_off) begin
                rx_en_nxt = 1'b0; // R12
            end else if (rx_on) begin
                rx_en_nxt = 1'b1; // R11
            end
            if (tx_off) begin
                tx_en_nxt = 1'b0; // R14 R22
            end else if (tx_on) begin
                tx_en_nxt = 1'b1; // R13
            end
        end
    end

    always_comb begin
        rd_data = 32'h0;
        case (1'b1)
            hit_rcp: rd_data = cur_ptr_r[0]; // R1 R2
            hit_rcc: rd_data = {16'h0, cur_cnt_r[0]};
            hit_tcp: rd_data = cur_ptr_r[TXC]; // R5
            hit_tcc: rd_data = {16'h0, cur_cnt_r[TXC]};
            hit_rnp: rd_data = nxt_ptr_r[0]; // R6
            hit_rnc: rd_data = {16'h0, nxt_cnt_r[0]}; // R7
            hit_tnp: rd_data = nxt_ptr_r[TXC]; // R8
            hit_tnc: rd_data = {16'h0, nxt_cnt_r[TXC]}; // R9
            hit_st: begin
                rd_data[peripheral_dma_pkg::STATE_RX_BIT] = rx_en_r; // R20
                rd_data[peripheral_dma_pkg::STATE_TX_BIT] = tx_en_r; // R21
            end
            default: rd_data = 32'h0;
        endcase
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            ack_r <= 1'b0;
            dat_o_r <= 32'h0;
            rx_en_r <= 1'b0;
            tx_en_r <= 1'b0;
        end else begin
            ack_r <= wb_req;
            dat_o_r <= wb_rd ? rd_data : 32'h0;
            rx_en_r <= rx_en_nxt;
            tx_en_r <= tx_en_nxt;
        end
    end

    // Transfer engine. Receive has priority when both channels are ready.
    wire rx_go = rx_en_r & (cur_cnt_r[0] != 16'h0) & RX_READY; // R3
    wire tx_go = tx_en_r & (cur_cnt_r[TXC] != 16'h0) & TX_READY & ~wr_r; // R4
    wire done = (state_r != peripheral_dma_pkg::ST_IDLE) & MEM_ACK;
    // A size code of 3 steps like a word; software is expected to use codes 0 to 2.
    wire [31:0] step = XFER_SIZE[1] ? 32'h4 : (XFER_SIZE[0] ? 32'h2 : 32'h1); // R24
    wire last = cur_cnt_r[dch_r] == 16'h1;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            peripheral_dma_pkg::ST_IDLE: begin
                if (rx_go) begin
                    state_nxt = peripheral_dma_pkg::ST_RX_MEM;
                end else if (tx_go) begin
                    state_nxt = peripheral_dma_pkg::ST_TX_MEM;
                end
            end
            peripheral_dma_pkg::ST_RX_MEM,
            peripheral_dma_pkg::ST_TX_MEM: begin
                if (MEM_ACK) begin
                    state_nxt = peripheral_dma_pkg::ST_IDLE;
                end
            end
            default: state_nxt = peripheral_dma_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            state_r <= peripheral_dma_pkg::ST_IDLE;
            dch_r <= 1'b0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            tx_hold_r <= 32'h0;
            cmd_r <= '0;
        end else begin
            state_r <= state_nxt;
            rd_r <= (state_r == peripheral_dma_pkg::ST_IDLE) & rx_go;
            wr_r <= (state_r == peripheral_dma_pkg::ST_TX_MEM) & MEM_ACK;
            if (state_r == peripheral_dma_pkg::ST_IDLE && rx_go) begin
                dch_r <= 1'b0;
                cmd_r <= '{we: 1'b1, size: XFER_SIZE, addr: cur_ptr_r[0],
                           wdata: RX_HOLD_DATA}; // R2
            end else if (state_r == peripheral_dma_pkg::ST_IDLE && tx_go) begin
                dch_r <= TXC;
                cmd_r <= '{we: 1'b0, size: XFER_SIZE, addr: cur_ptr_r[TXC],
                           wdata: 32'h0}; // R5
            end
            if (state_r == peripheral_dma_pkg::ST_TX_MEM && MEM_ACK) begin
                tx_hold_r <= MEM_RDATA;
            end
        end
    end

    // Channel storage. A software write in the same cycle as an engine update wins,
    // so a pointer moved mid-transfer is used for the following items.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int c = 0; c < 2; c++) begin
                cur_ptr_r[c] <= peripheral_dma_pkg::PTR_RESET;
                cur_cnt_r[c] <= peripheral_dma_pkg::CNT_RESET;
                nxt_ptr_r[c] <= peripheral_dma_pkg::PTR_RESET;
                nxt_cnt_r[c] <= peripheral_dma_pkg::CNT_RESET;
                end_r[c] <= peripheral_dma_pkg::END_FLAG_RESET;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                // The clear comes first so an end event in the same cycle still sets the flag.
                if ((wr_cc[c] && new_cc[15:0] != 16'h0) ||
                    (wr_nc[c] && new_nc[15:0] != 16'h0)) begin
                    end_r[c] <= 1'b0; // R26
                end
                if (done && dch_r == c[0]) begin
                    if (last) begin
                        end_r[c] <= 1'b1; // R25
                    end
                    if (last && nxt_cnt_r[c] != 16'h0) begin
                        cur_ptr_r[c] <= nxt_ptr_r[c]; // R23
                        cur_cnt_r[c] <= nxt_cnt_r[c];
                        nxt_ptr_r[c] <= peripheral_dma_pkg::PTR_RESET;
                        nxt_cnt_r[c] <= peripheral_dma_pkg::CNT_RESET;
                    end else begin
                        cur_ptr_r[c] <= cur_ptr_r[c] + step; // R24
                        cur_cnt_r[c] <= cur_cnt_r[c] - 16'h1;
                    end
                end else if (state_r == peripheral_dma_pkg::ST_IDLE &&
                             cur_cnt_r[c] == 16'h0 && nxt_cnt_r[c] != 16'h0) begin
                    cur_ptr_r[c] <= nxt_ptr_r[c]; // R23
                    cur_cnt_r[c] <= nxt_cnt_r[c];
                    nxt_ptr_r[c] <= peripheral_dma_pkg::PTR_RESET;
                    nxt_cnt_r[c] <= peripheral_dma_pkg::CNT_RESET;
                end
                if (wr_cp[c]) begin
                    cur_ptr_r[c] <= new_cp; // R2 R5
                end
                if (wr_cc[c]) begin
                    cur_cnt_r[c] <= new_cc[15:0]; // R3 R4
                end
                if (wr_np[c]) begin
                    nxt_ptr_r[c] <= new_np; // R6 R8
                end
                if (wr_nc[c]) begin
                    nxt_cnt_r[c] <= new_nc[15:0]; // R7 R9
                end
            end
        end
    end

    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = dat_o_r;
    assign RX_HOLD_RD = rd_r;
    assign TX_HOLD_WR = wr_r;
    assign TX_HOLD_DATA = tx_hold_r;
    assign MEM_REQ = state_r != peripheral_dma_pkg::ST_IDLE;
    assign MEM_CMD = cmd_r;
    assign RX_END = end_r[0];
    assign RX_FULL = end_r[0] & (cur_cnt_r[0] == 16'h0) & (nxt_cnt_r[0] == 16'h0); // R25
    assign TX_END = end_r[TXC];
    assign TX_EMPTY = end_r[TXC] & (cur_cnt_r[TXC] == 16'h0) & (nxt_cnt_r[TXC] == 16'h0);

    // The checks watch the unit's own state; nothing is assumed of the bus or far side.
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);

    wire quiet = wb_wr == 1'b0;

    chk_rx_start_gate: assert property ( // R3
        (state_r == peripheral_dma_pkg::ST_IDLE && state_nxt == peripheral_dma_pkg::ST_RX_MEM)
        |-> rx_en_r && cur_cnt_r[0] != 16'h0 ##1 RX_HOLD_RD && MEM_REQ && MEM_CMD.we)
        else $error("receive item started without enable or count");

    chk_tx_start_gate: assert property ( // R4
        (state_r == peripheral_dma_pkg::ST_IDLE && state_nxt == peripheral_dma_pkg::ST_TX_MEM)
        |-> tx_en_r && cur_cnt_r[TXC] != 16'h0 ##1 MEM_REQ && !MEM_CMD.we)
        else $error("transmit item started without enable or count");

    chk_rx_dis_wins: assert property ( // R12
        rx_off |=> !rx_en_r ##1 !rx_en_r || $past(rx_on))
        else $error("receive disable did not take effect");

    chk_tx_dis_wins: assert property ( // R22
        tx_off && tx_on |=> !tx_en_r)
        else $error("transmit enable beat disable");

    chk_half_rx_excl: assert property ( // R15
        HALF_DUPLEX && rx_on && !rx_off && !tx_off |=> rx_en_r && !tx_en_r)
        else $error("half duplex receive enable left transmit on");

    chk_half_dis_both: assert property ( // R18
        HALF_DUPLEX && (tx_off || rx_off) |=> !rx_en_r && !tx_en_r)
        else $error("half duplex disable left a direction on");

    chk_ptr_step_size: assert property ( // R24
        done && !last && quiet |=> cur_ptr_r[dch_r] == $past(cur_ptr_r[dch_r]) + $past(step)
        && cur_cnt_r[dch_r] == $past(cur_cnt_r[dch_r]) - 16'h1)
        else $error("pointer or count did not advance by one item");

    chk_end_on_zero: assert property ( // R25
        done && last |=> end_r[dch_r] ##1 !MEM_REQ || end_r[dch_r] || !quiet)
        else $error("end flag not set when count reached zero");

    chk_next_reload: assert property ( // R23
        done && last && nxt_cnt_r[dch_r] != 16'h0 && quiet
        |=> cur_cnt_r[dch_r] == $past(nxt_cnt_r[dch_r]) && nxt_cnt_r[dch_r] == 16'h0)
        else $error("next pair not moved into current");

    chk_wb_answer: assert property ( // R1
        wb_req |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("bus request not answered in one cycle");

endmodule : peripheral_dma_unit

// file: common/peripheral_dma_pkg.sv
/*
 * Constants, register map and carrier types for the peripheral DMA channel pair.
 * Assumes one clock domain and software access over a classic Wishbone slave port.
 */
// Functional notes
// R1: Ten channel registers sit at consecutive words from 0x100 to 0x124.
// R2: Current receive pointer is the memory address where received data is written.
// R3: Receive count zero halts receive; nonzero starts it while receive is enabled.
// R4: Transmit count zero halts transmit; nonzero starts it while transmit is enabled.
// R5: Current transmit pointer is the memory address outgoing data is read from.
// R6: Next receive pointer holds the address of the queued receive buffer.
// R7: Next receive count holds the size of the queued receive buffer.
// R8: Next transmit pointer holds the address of the queued transmit buffer.
// R9: Next transmit count holds the size of the queued transmit buffer.
// R10: Half duplex: receive and transmit registers alias one channel storage.
// R11: Writing receive enable one enables receive unless receive disable is also one.
// R12: Writing receive disable one disables receive requests; zero does nothing.
// R13: Writing transmit enable one enables transmit requests; zero does nothing.
// R14: Writing transmit disable one disables transmit requests; zero does nothing.
// R15: Half duplex: enabling receive disables transmit.
// R16: Software never sets both enables at once on a half duplex channel.
// R17: Half duplex: disabling receive also disables transmit.
// R18: Half duplex: disabling transmit also disables receive.
// R19: Half duplex: transmit enable acts only when receive enable is not written.
// R20: Status bit reports receive requests enabled as one, disabled as zero.
// R21: Status bit reports transmit requests enabled as one, disabled as zero.
// R22: Transmit enable and disable written together leave transmit disabled.
// R23: Current count at zero with next nonzero: next pair moves to current, next cleared.
// R24: Pointer advances one, two or four bytes per byte, half-word or word item.
// R25: End flag when current count hits zero; full/empty when next is zero too.
// R26: End flag clears when software writes a nonzero current or next count.
package peripheral_dma_pkg;

    localparam int ADDR_W = 12;

    localparam logic [ADDR_W-1:0] OFF_RX_CUR_PTR = 12'h100;
    localparam logic [ADDR_W-1:0] OFF_RX_CUR_CNT = 12'h104;
    localparam logic [ADDR_W-1:0] OFF_TX_CUR_PTR = 12'h108;
    localparam logic [ADDR_W-1:0] OFF_TX_CUR_CNT = 12'h10c;
    localparam logic [ADDR_W-1:0] OFF_RX_NXT_PTR = 12'h110;
    localparam logic [ADDR_W-1:0] OFF_RX_NXT_CNT = 12'h114;
    localparam logic [ADDR_W-1:0] OFF_TX_NXT_PTR = 12'h118;
    localparam logic [ADDR_W-1:0] OFF_TX_NXT_CNT = 12'h11c;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h120;
    localparam logic [ADDR_W-1:0] OFF_STATE = 12'h124;

    localparam logic [31:0] PTR_RESET = 32'h0;
    localparam logic [15:0] CNT_RESET = 16'h0;
    localparam logic END_FLAG_RESET = 1'h1;

    localparam int CTRL_RX_EN_BIT = 0;
    localparam int CTRL_RX_DIS_BIT = 1;
    localparam int CTRL_TX_EN_BIT = 8;
    localparam int CTRL_TX_DIS_BIT = 9;
    localparam int STATE_RX_BIT = 0;
    localparam int STATE_TX_BIT = 8;

    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RX_MEM,
        ST_TX_MEM
    } engine_state_t;

    typedef struct packed {
        logic we;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_cmd_t;

endpackage : peripheral_dma_pkg

// file: tb/far_side_model.sv
/*
 * Far-side model: serial peripheral ready lines and holding registers, plus a
 * memory port that answers one to four cycles after a request appears.
 * Assumes one MCLK domain; the bench steers data wishes through RX_WANT and TX_WANT.
 */
module far_side_model (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic RX_WANT,
    input wire logic TX_WANT,
    input wire logic RX_HOLD_RD,
    input wire logic TX_HOLD_WR,
    input wire logic [31:0] TX_HOLD_DATA,
    input wire logic MEM_REQ,
    input wire peripheral_dma_pkg::mem_cmd_t MEM_CMD,
    output logic RX_READY,
    output logic [31:0] RX_HOLD_DATA,
    output logic TX_READY,
    output logic MEM_ACK,
    output logic [31:0] MEM_RDATA,
    output logic [31:0] WR_ADDR,
    output logic [31:0] WR_DATA,
    output logic [31:0] TX_GOT,
    output int WR_N,
    output int TX_N
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] rx_val_r;
    logic [1:0] wait_r;
    // Outside a valid phase the lines show inverted data so stale values never match.
    assign RX_HOLD_DATA = RX_READY ? rx_val_r : ~rx_val_r;
    assign MEM_RDATA = MEM_ACK ? ~MEM_CMD.addr : MEM_CMD.addr;
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            RX_READY <= 1'b0;
            TX_READY <= 1'b0;
            MEM_ACK <= 1'b0;
            wait_r <= 2'h0;
            rx_val_r <= 32'h10000000;
            WR_N <= 0;
            TX_N <= 0;
            WR_ADDR <= 32'h0;
            WR_DATA <= 32'h0;
            TX_GOT <= 32'h0;
        end else begin
            RX_READY <= RX_WANT && !RX_HOLD_RD;
            TX_READY <= TX_WANT;
            // Address bits 3:2 pick the latency, so both prompt and slow answers occur.
            MEM_ACK <= MEM_REQ && !MEM_ACK && wait_r == MEM_CMD.addr[3:2];
            wait_r <= (MEM_REQ && !MEM_ACK) ? wait_r + 2'h1 : 2'h0;
            if (RX_HOLD_RD) begin
                rx_val_r <= rx_val_r + 32'h11;
            end
            if (MEM_ACK && MEM_CMD.we) begin
                WR_N <= WR_N + 1;
                WR_ADDR <= MEM_CMD.addr;
                WR_DATA <= MEM_CMD.wdata;
            end
            if (TX_HOLD_WR) begin
                TX_N <= TX_N + 1;
                TX_GOT <= TX_HOLD_DATA;
            end
        end
    end
endmodule : far_side_model

// file: tb/tb.sv
/*
 * Self-checking bench: a full and a half duplex channel share one register bus.
 * Assumes the far-side model drives the full duplex channel; the other idles.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic rx_want = 1'b0, tx_want = 1'b0, ack, ack2;
    logic [11:0] adr = 12'h0;
    logic [3:0] sel = 4'h0;
    logic [1:0] xsize = 2'h2, st = 2'h0, st2 = 2'h0;
    logic [31:0] wdat = 32'h0, rdat, rdat2, q, q2, p, pn, c, seed = 32'hb1bca58f;
    logic [31:0] v [8];
    logic [31:0] cw [11] = '{32'h0, 32'h1, 32'h3, 32'h100, 32'h300, 32'h1, 32'h200, 32'h100,
                             32'h2, 32'h201, 32'h102};
    logic rx_rdy, tx_rdy, rx_rd, tx_wr, mreq, mack, rx_end, rx_full, tx_end, tx_empty;
    logic [31:0] rx_hd, tx_hd, mrd, wr_addr, wr_data, tx_got;
    int wr_n, tx_n, idx, miscompares = 0, cmp_count = 0, cycles = 0;
    peripheral_dma_pkg::mem_cmd_t mcmd;
    always #5 mclk = ~mclk;
    peripheral_dma_unit #(.HALF_DUPLEX(1'b0)) DUT (.MCLK(mclk), .RESETN(resetn),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .XFER_SIZE(xsize),
        .RX_READY(rx_rdy), .RX_HOLD_DATA(rx_hd), .RX_HOLD_RD(rx_rd), .TX_READY(tx_rdy),
        .TX_HOLD_DATA(tx_hd), .TX_HOLD_WR(tx_wr), .MEM_REQ(mreq), .MEM_CMD(mcmd),
        .MEM_ACK(mack), .MEM_RDATA(mrd), .RX_END(rx_end), .RX_FULL(rx_full),
        .TX_END(tx_end), .TX_EMPTY(tx_empty));
    peripheral_dma_unit #(.HALF_DUPLEX(1'b1)) DUT2 (.MCLK(mclk), .RESETN(resetn),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat2), .WB_ACK_O(ack2), .XFER_SIZE(xsize),
        .RX_READY(1'b0), .RX_HOLD_DATA(rx_hd), .RX_HOLD_RD(), .TX_READY(1'b0),
        .TX_HOLD_DATA(), .TX_HOLD_WR(), .MEM_REQ(), .MEM_CMD(), .MEM_ACK(1'b0),
        .MEM_RDATA(mrd), .RX_END(), .RX_FULL(), .TX_END(), .TX_EMPTY());
    far_side_model far (.MCLK(mclk), .RESETN(resetn), .RX_WANT(rx_want),
        .TX_WANT(tx_want), .RX_HOLD_RD(rx_rd), .TX_HOLD_WR(tx_wr), .TX_HOLD_DATA(tx_hd),
        .MEM_REQ(mreq), .MEM_CMD(mcmd), .RX_READY(rx_rdy), .RX_HOLD_DATA(rx_hd),
        .TX_READY(tx_rdy), .MEM_ACK(mack), .MEM_RDATA(mrd), .WR_ADDR(wr_addr),
        .WR_DATA(wr_data), .TX_GOT(tx_got), .WR_N(wr_n), .TX_N(tx_n));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Expected {tx, rx} request state after one control write; disable beats enable.
    function automatic logic [1:0] ctl_model(input logic hd, input logic [1:0] s,
                                             input logic [31:0] w);
        logic rx, tx;
        rx = s[0];
        tx = s[1];
        if (!hd) begin
            rx = (rx | w[0]) & ~w[1];
            tx = (tx | w[8]) & ~w[9];
        end else if (w[1] | w[9]) begin
            rx = 1'b0;
            tx = 1'b0;
        end else if (w[0]) begin
            rx = 1'b1;
            tx = 1'b0;
        end else if (w[8]) begin
            rx = 1'b0;
            tx = 1'b1;
        end
        return {tx, rx};
    endfunction : ctl_model
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        wdat <= d;
        do @(posedge mclk); while (ack !== 1'b1);
        q = rdat;
        q2 = rdat2;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus
    task automatic ctl(input logic [31:0] w);
        bus(1'b1, 12'h120, w);
        st = ctl_model(1'b0, st, w);
        st2 = ctl_model(1'b1, st2, w);
        bus(1'b0, 12'h124, 32'h0);
        chk(q, {23'h0, st[1], 7'h0, st[0]}, "full duplex state");
        chk(q2, {23'h0, st2[1], 7'h0, st2[0]}, "half duplex state");
    endtask : ctl
    task automatic give_verdict();
        $display("compares %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            $display("unexpected at %0t: run too long", $time);
            give_verdict();
        end
    end
    initial begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        chk({28'h0, rx_end, rx_full, tx_end, tx_empty}, 32'hf, "reset flags");
        for (int i = 0; i < 11; i++) begin
            bus(1'b0, 12'h100 + 12'(4 * i), 32'h0);
            chk(q, 32'h0, "reset value or unmapped read");
            chk(q2, 32'h0, "half duplex reset value");
        end
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            v[i] = rnd();
            bus(1'b1, 12'h100 + 12'(4 * i), v[i]);
        end
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 12'h100 + 12'(4 * i), 32'h0);
            chk(q, i[0] ? v[i] & 32'hffff : v[i], "read back");
            chk(q2, i[0] ? v[i | 2] & 32'hffff : v[i | 2], "aliased read");
        end
        $display("test registers done");
        bus(1'b1, 12'h124, 32'hffffffff);
        bus(1'b0, 12'h120, 32'h0);
        chk(q, 32'h0, "control reads zero");
        foreach (cw[k]) begin
            ctl(cw[k]);
        end
        for (int i = 0; i < 16; i++) begin
            c = rnd() & 32'h303;
            c[8] = c[8] & ~c[0];
            ctl(c);
        end
        ctl(32'h202);
        $display("test control done");
        idx = 0;
        for (int sz = 0; sz < 3; sz++) begin
            xsize <= 2'(sz);
            p = rnd();
            pn = rnd();
            bus(1'b1, 12'h100, p);
            bus(1'b1, 12'h104, 32'h2);
            chk(32'(rx_end), 32'h0, "end flag cleared");
            bus(1'b1, 12'h110, pn);
            bus(1'b1, 12'h114, 32'h1);
            ctl(32'h1);
            rx_want <= 1'b1;
            for (int k = 0; k < 3; k++) begin
                while (wr_n <= idx) @(posedge mclk);
                chk(wr_addr, k < 2 ? p + 32'(k << sz) : pn, "receive address");
                chk(32'(mcmd.size), 32'(sz), "item size");
                if (sz == 2) chk(wr_data, 32'h10000000 + 32'h11 * idx, "receive data");
                idx++;
            end
            repeat (20) @(posedge mclk);
            chk(32'(wr_n), 32'(idx), "receive halts at zero");
            chk({30'h0, rx_end, rx_full}, 32'h3, "receive end and full");
            bus(1'b0, 12'h114, 32'h0);
            chk(q, 32'h0, "next count cleared");
            bus(1'b0, 12'h100, 32'h0);
            chk(q, pn + 32'(1 << sz), "pointer after reload");
            rx_want <= 1'b0;
            ctl(32'h2);
        end
        $display("test receive done");
        xsize <= 2'h2;
        bus(1'b1, 12'h11c, 32'h0);
        bus(1'b1, 12'h10c, 32'h0);
        ctl(32'h100);
        tx_want <= 1'b1;
        repeat (20) @(posedge mclk);
        chk(32'(tx_n), 32'h0, "transmit halted at zero");
        p = rnd();
        bus(1'b1, 12'h108, p);
        bus(1'b1, 12'h10c, 32'h2);
        for (int k = 0; k < 2; k++) begin
            while (tx_n <= k) @(posedge mclk);
            chk(tx_got, ~(p + 32'(4 * k)), "transmit data");
        end
        repeat (20) @(posedge mclk);
        chk(32'(tx_n), 32'h2, "transmit count");
        chk({30'h0, tx_end, tx_empty}, 32'h3, "transmit end and empty");
        tx_want <= 1'b0;
        ctl(32'h200);
        $display("test transmit done");
        give_verdict();
    end
endmodule : tb
